/* rtl/pbae_regs.svh */
// Width, field position and reset constants for the packed byte add slice
`ifndef PBAE_REGS_SVH
`define PBAE_REGS_SVH

// ****************************************************************
// Data path widths
// ****************************************************************
`define PBAE_DATA_W 32
`define PBAE_PAIR_W 64
`define PBAE_ACC_W 40
`define PBAE_HALF_W 16
`define PBAE_BYTE_W 8
`define PBAE_LANES 4
`define PBAE_OFF_W 2
`define PBAE_REG_IDX_W 3

// ****************************************************************
// Field positions
// ****************************************************************
`define PBAE_HALF_HI_MSB 31
`define PBAE_HALF_HI_LSB 16
`define PBAE_HALF_LO_MSB 15
`define PBAE_HALF_LO_LSB 0
`define PBAE_IDX_OFF_MSB 1
`define PBAE_IDX_OFF_LSB 0

// ****************************************************************
// Reset and fill values
// ****************************************************************
`define PBAE_RST_WORD 32'h0000_0000
`define PBAE_RST_IDX 3'h0
`define PBAE_LANE_PAD 8'h00

`endif

/* rtl/pbae_pkg.sv */
// Types shared by the packed byte add and accumulator extract slice
`default_nettype none
`include "pbae_regs.svh"

package pbae_pkg;

  // ****************************************************************
  // Operation codes from the decode stage
  // ****************************************************************
  typedef enum logic [1:0] {
    PBAE_OP_IDLE          = 2'b00,
    PBAE_OP_ACC_EXTRACT   = 2'b01,
    PBAE_OP_QUAD_BYTE_ADD = 2'b10,
    PBAE_OP_RSVD          = 2'b11
  } pbae_op_type;

  // Source register pair as read from the register file
  typedef struct packed {
    logic [`PBAE_DATA_W-1:0] pair_upper_register;
    logic [`PBAE_DATA_W-1:0] pair_lower_register;
  } pbae_pair_type;

  // Issue request from decode
  typedef struct packed {
    logic valid;
    pbae_op_type op;
    logic reverse;
    logic parallel;
    logic [`PBAE_REG_IDX_W-1:0] first_dest;
    logic [`PBAE_REG_IDX_W-1:0] second_dest;
  } pbae_req_type;

  // Write-back to the register file
  typedef struct packed {
    logic valid;
    logic [`PBAE_REG_IDX_W-1:0] first_dest;
    logic [`PBAE_DATA_W-1:0] first_data;
    logic [`PBAE_REG_IDX_W-1:0] second_dest;
    logic [`PBAE_DATA_W-1:0] second_data;
  } pbae_result_type;

endpackage
`default_nettype wire

/* rtl/pbae_byte_align.sv */
// Byte aligner: picks four bytes out of a register pair by offset
`timescale 1ns/1ps
`default_nettype none
`include "pbae_regs.svh"

module pbae_byte_align (
  input wire pbae_pkg::pbae_pair_type i_pair,
  input wire logic i_reverse,
  input wire logic [`PBAE_OFF_W-1:0] i_offset,
  output logic [`PBAE_DATA_W-1:0] o_word
);

  logic [`PBAE_PAIR_W-1:0] pair_w;
  logic [`PBAE_PAIR_W-1:0] shifted_w;

  // Reverse swaps the two registers before selection
  assign pair_w = i_reverse ?
    {i_pair.pair_lower_register, i_pair.pair_upper_register} :
    {i_pair.pair_upper_register, i_pair.pair_lower_register};

  // Offset n selects bytes n+3 down to n
  assign shifted_w = pair_w >> (i_offset * `PBAE_BYTE_W);
  assign o_word = shifted_w[`PBAE_DATA_W-1:0];

endmodule
`default_nettype wire

/* rtl/pbae_half_sum.sv */
// Accumulator half-word adder with sign extension of both halves
`timescale 1ns/1ps
`default_nettype none
`include "pbae_regs.svh"

module pbae_half_sum (
  input wire logic [`PBAE_ACC_W-1:0] i_acc,
  output logic [`PBAE_DATA_W-1:0] o_sum
);

  logic [`PBAE_HALF_W-1:0] high_half;
  logic [`PBAE_HALF_W-1:0] low_half;
  logic [`PBAE_DATA_W-1:0] high_ext;
  logic [`PBAE_DATA_W-1:0] low_ext;

  // Split bits 31:16 and 15:0; the guard bits take no part
  assign high_half = i_acc[`PBAE_HALF_HI_MSB:`PBAE_HALF_HI_LSB];
  assign low_half = i_acc[`PBAE_HALF_LO_MSB:`PBAE_HALF_LO_LSB];

  // Sign extend each half to the full word
  assign high_ext = {{(`PBAE_DATA_W-`PBAE_HALF_W){high_half[`PBAE_HALF_W-1]}},
                     high_half};
  assign low_ext = {{(`PBAE_DATA_W-`PBAE_HALF_W){low_half[`PBAE_HALF_W-1]}},
                    low_half};

  // Signed sum cannot overflow 32 bits, so no saturation
  assign o_sum = high_ext + low_ext;

endmodule
`default_nettype wire

/* rtl/pbae_core.sv */
// Packed byte add and dual accumulator extract datapath slice
//
// Summary of operation
// - Extract adds each accumulator's two half-words into a 32-bit register.
// - Each 16-bit half is sign extended first, giving a signed sum.
// - Accumulator one sum goes to first destination, zero to second.
// - Quad byte add sums four unsigned byte pairs, zero-extended to 16 bits.
// - First dest gets lanes 1:0, second dest gets lanes 3:2.
// - First pair's byte offset is index register zero's two low bits.
// - Second pair's byte offset is index register one's two low bits.
// - Upper register holds bytes 7-4; offsets 0..3 pick bytes n+3..n.
// - Reverse swaps the pair's registers before bytes are selected.
// - Quad byte add suppresses misalignment faults of parallel word loads.
// - Both operations are accepted inside a multi-issue slot too.
// - Both operations decode as 32-bit instruction encodings.
`timescale 1ns/1ps
`default_nettype none
`include "pbae_regs.svh"

module pbae_core (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire pbae_pkg::pbae_req_type i_req,
  input wire logic [`PBAE_ACC_W-1:0] i_accumulator_zero,
  input wire logic [`PBAE_ACC_W-1:0] i_accumulator_one,
  input wire pbae_pkg::pbae_pair_type i_src_pair_0,
  input wire pbae_pkg::pbae_pair_type i_src_pair_1,
  input wire logic [`PBAE_DATA_W-1:0] i_index_reg_zero,
  input wire logic [`PBAE_DATA_W-1:0] i_index_reg_one,
  output pbae_pkg::pbae_result_type o_result,
  output logic o_suppress_misalign,
  output logic o_insn_len32,
  output logic o_flags_write
);

  // ****************************************************************
  // Decode of the issue request
  // ****************************************************************
  logic is_extract;
  logic is_quad_add;
  logic accept;

  // Parallel slot bit is deliberately not a condition here
  assign is_extract = i_req.valid &&
                      (i_req.op == pbae_pkg::PBAE_OP_ACC_EXTRACT);
  assign is_quad_add = i_req.valid &&
                       (i_req.op == pbae_pkg::PBAE_OP_QUAD_BYTE_ADD);
  assign accept = is_extract || is_quad_add;

  // ****************************************************************
  // Accumulator extraction
  // ****************************************************************
  logic [`PBAE_DATA_W-1:0] acc_one_sum;
  logic [`PBAE_DATA_W-1:0] acc_zero_sum;

  // Half-word adders, one per accumulator
  pbae_half_sum u_sum_acc_one (
    .i_acc (i_accumulator_one),
    .o_sum (acc_one_sum)
  );
  pbae_half_sum u_sum_acc_zero (
    .i_acc (i_accumulator_zero),
    .o_sum (acc_zero_sum)
  );

  // ****************************************************************
  // Byte alignment of the two source pairs
  // ****************************************************************
  logic [`PBAE_OFF_W-1:0] offset_0;
  logic [`PBAE_OFF_W-1:0] offset_1;
  logic [`PBAE_DATA_W-1:0] aligned_0;
  logic [`PBAE_DATA_W-1:0] aligned_1;

  // Offsets from the low bits of the index registers
  assign offset_0 = i_index_reg_zero[`PBAE_IDX_OFF_MSB:`PBAE_IDX_OFF_LSB];
  assign offset_1 = i_index_reg_one[`PBAE_IDX_OFF_MSB:`PBAE_IDX_OFF_LSB];

  // Pair contents arrive from a legal pair chosen by decode
  pbae_byte_align u_align_0 (
    .i_pair (i_src_pair_0),
    .i_reverse (i_req.reverse),
    .i_offset (offset_0),
    .o_word (aligned_0)
  );
  pbae_byte_align u_align_1 (
    .i_pair (i_src_pair_1),
    .i_reverse (i_req.reverse),
    .i_offset (offset_1),
    .o_word (aligned_1)
  );

  // ****************************************************************
  // Four byte lanes, zero extended
  // ****************************************************************
  logic [`PBAE_HALF_W-1:0] lane_sum [`PBAE_LANES];

  // Largest sum is 510, so 16 bits never wrap
  genvar g_lane;
  generate
    for (g_lane = 0; g_lane < `PBAE_LANES; g_lane++) begin : g_lanes
      assign lane_sum[g_lane] =
        {`PBAE_LANE_PAD, aligned_0[g_lane*`PBAE_BYTE_W +: `PBAE_BYTE_W]} +
        {`PBAE_LANE_PAD, aligned_1[g_lane*`PBAE_BYTE_W +: `PBAE_BYTE_W]};
    end
  endgenerate

  // ****************************************************************
  // Result selection
  // ****************************************************************
  logic [`PBAE_DATA_W-1:0] first_data_d;
  logic [`PBAE_DATA_W-1:0] second_data_d;

  // Route by operation
  always_comb begin
    first_data_d = `PBAE_RST_WORD;
    second_data_d = `PBAE_RST_WORD;
    case (i_req.op)
      pbae_pkg::PBAE_OP_ACC_EXTRACT: begin
        first_data_d = acc_one_sum;
        second_data_d = acc_zero_sum;
      end
      pbae_pkg::PBAE_OP_QUAD_BYTE_ADD: begin
        first_data_d = {lane_sum[1], lane_sum[0]};
        second_data_d = {lane_sum[3], lane_sum[2]};
      end
      default: begin
        first_data_d = `PBAE_RST_WORD;
        second_data_d = `PBAE_RST_WORD;
      end
    endcase
  end

  // ****************************************************************
  // Write-back register
  // ****************************************************************
  // Valid pulses one cycle after issue; indices and data hold
  // One process owns the whole result word, so no field has two writers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_result.valid <= 1'b0;
      o_result.first_dest <= `PBAE_RST_IDX;
      o_result.second_dest <= `PBAE_RST_IDX;
      o_result.first_data <= `PBAE_RST_WORD;
      o_result.second_data <= `PBAE_RST_WORD;
    end else begin
      o_result.valid <= accept;
      if (accept) begin
        o_result.first_dest <= i_req.first_dest;
        o_result.second_dest <= i_req.second_dest;
        o_result.first_data <= first_data_d;
        o_result.second_data <= second_data_d;
      end
    end
  end

  // ****************************************************************
  // Side-band controls to the core
  // ****************************************************************
  // Misalignment mask for loads of the same slot
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_suppress_misalign <= 1'b0;
    end else begin
      o_suppress_misalign <= is_quad_add;
    end
  end

  // Fetch advances by a 32-bit encoding for either operation
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_insn_len32 <= 1'b0;
    end else begin
      o_insn_len32 <= accept;
    end
  end

  // Status flags are never written by this slice
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flags_write <= 1'b0;
    end else begin
      o_flags_write <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Reference half-word sum, written independently of the adder
  function automatic logic [`PBAE_DATA_W-1:0] ref_half_sum(
    input logic [`PBAE_ACC_W-1:0] acc
  );
    logic signed [`PBAE_HALF_W-1:0] hi;
    logic signed [`PBAE_HALF_W-1:0] lo;
    logic signed [`PBAE_DATA_W-1:0] s;
    hi = acc[`PBAE_HALF_HI_MSB:`PBAE_HALF_HI_LSB];
    lo = acc[`PBAE_HALF_LO_MSB:`PBAE_HALF_LO_LSB];
    s = `PBAE_DATA_W'(hi) + `PBAE_DATA_W'(lo);
    return s;
  endfunction

  // Reference byte pick from a pair at a given offset
  function automatic logic [`PBAE_BYTE_W-1:0] ref_byte(
    input pbae_pkg::pbae_pair_type pair,
    input logic rev,
    input logic [`PBAE_OFF_W-1:0] off,
    input int lane
  );
    logic [`PBAE_DATA_W-1:0] lo_reg;
    logic [`PBAE_DATA_W-1:0] hi_reg;
    int idx;
    lo_reg = rev ? pair.pair_upper_register : pair.pair_lower_register;
    hi_reg = rev ? pair.pair_lower_register : pair.pair_upper_register;
    idx = lane + int'(off);
    if (idx < `PBAE_LANES) begin
      return lo_reg[idx*`PBAE_BYTE_W +: `PBAE_BYTE_W];
    end
    return hi_reg[(idx-`PBAE_LANES)*`PBAE_BYTE_W +: `PBAE_BYTE_W];
  endfunction

  // Reference lane sum using index register offsets
  function automatic logic [`PBAE_HALF_W-1:0] ref_lane(
    input pbae_pkg::pbae_pair_type p0,
    input pbae_pkg::pbae_pair_type p1,
    input logic rev,
    input logic [`PBAE_DATA_W-1:0] ix0,
    input logic [`PBAE_DATA_W-1:0] ix1,
    input int lane
  );
    logic [`PBAE_HALF_W-1:0] a;
    logic [`PBAE_HALF_W-1:0] b;
    a = {`PBAE_LANE_PAD, ref_byte(p0, rev, ix0[1:0], lane)};
    b = {`PBAE_LANE_PAD, ref_byte(p1, rev, ix1[1:0], lane)};
    return a + b;
  endfunction

  default clocking cb_main @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_extract_issue;
    i_req.valid && (i_req.op == pbae_pkg::PBAE_OP_ACC_EXTRACT);
  endsequence

  sequence s_quad_issue;
    i_req.valid && (i_req.op == pbae_pkg::PBAE_OP_QUAD_BYTE_ADD);
  endsequence

  property p_extract_acc_one;
    s_extract_issue |=> o_result.valid &&
      (o_result.first_data == ref_half_sum($past(i_accumulator_one)));
  endproperty
  a_extract_acc_one: assert property (p_extract_acc_one)
    else $error("first destination lacks accumulator one sum");

  property p_extract_acc_zero;
    s_extract_issue |=>
      (o_result.second_data == ref_half_sum($past(i_accumulator_zero))) &&
      (o_result.second_dest == $past(i_req.second_dest));
  endproperty
  a_extract_acc_zero: assert property (p_extract_acc_zero)
    else $error("second destination lacks accumulator zero sum");

  property p_quad_low_word;
    s_quad_issue |=> o_result.first_data == {
      ref_lane($past(i_src_pair_0), $past(i_src_pair_1),
               $past(i_req.reverse), $past(i_index_reg_zero),
               $past(i_index_reg_one), 1),
      ref_lane($past(i_src_pair_0), $past(i_src_pair_1),
               $past(i_req.reverse), $past(i_index_reg_zero),
               $past(i_index_reg_one), 0)};
  endproperty
  a_quad_low_word: assert property (p_quad_low_word)
    else $error("quad add lanes 1:0 wrong in first destination");

  property p_quad_high_word;
    s_quad_issue |=> o_result.second_data == {
      ref_lane($past(i_src_pair_0), $past(i_src_pair_1),
               $past(i_req.reverse), $past(i_index_reg_zero),
               $past(i_index_reg_one), 3),
      ref_lane($past(i_src_pair_0), $past(i_src_pair_1),
               $past(i_req.reverse), $past(i_index_reg_zero),
               $past(i_index_reg_one), 2)};
  endproperty
  a_quad_high_word: assert property (p_quad_high_word)
    else $error("quad add lanes 3:2 wrong in second destination");

  property p_quad_no_wrap;
    s_quad_issue |=>
      (o_result.first_data[`PBAE_HALF_W-1 -: `PBAE_BYTE_W-1] == 7'h00) &&
      (o_result.second_data[`PBAE_HALF_W-1 -: `PBAE_BYTE_W-1] == 7'h00);
  endproperty
  a_quad_no_wrap: assert property (p_quad_no_wrap)
    else $error("quad add lane sum exceeds nine bits");

  property p_misalign_mask;
    s_quad_issue |=> o_suppress_misalign ##1
      (o_suppress_misalign == $past(is_quad_add));
  endproperty
  a_misalign_mask: assert property (p_misalign_mask)
    else $error("misalignment mask not raised for quad add");

  property p_parallel_accept;
    (i_req.valid && i_req.parallel &&
      ((i_req.op == pbae_pkg::PBAE_OP_ACC_EXTRACT) ||
       (i_req.op == pbae_pkg::PBAE_OP_QUAD_BYTE_ADD))) |=> o_result.valid;
  endproperty
  a_parallel_accept: assert property (p_parallel_accept)
    else $error("operation in multi-issue slot was not accepted");

  property p_len32;
    o_insn_len32 == $past(accept);
  endproperty
  a_len32: assert property (p_len32)
    else $error("instruction length strobe does not follow issue");

  property p_no_flags;
    (s_extract_issue or s_quad_issue) |=> !o_flags_write [*2];
  endproperty
  a_no_flags: assert property (p_no_flags)
    else $error("status flags written by packed add slice");

endmodule
`default_nettype wire

/* tb/pbae_issue_model.sv */
// Decode and register file model that feeds the datapath slice
`timescale 1ns/1ps
`default_nettype none

module pbae_issue_model (
  input wire pbae_pkg::pbae_req_type i_cmd,
  input wire logic i_pair_swap,
  input wire logic [7:0][31:0] i_dreg,
  input wire logic [1:0][39:0] i_acc,
  input wire logic [1:0][31:0] i_idx,
  output var pbae_pkg::pbae_req_type o_req,
  output var pbae_pkg::pbae_pair_type o_pair_0,
  output var pbae_pkg::pbae_pair_type o_pair_1,
  output logic [39:0] o_acc_zero,
  output logic [39:0] o_acc_one,
  output logic [31:0] o_idx_zero,
  output logic [31:0] o_idx_one
);
  pbae_pkg::pbae_pair_type pair_low;
  pbae_pkg::pbae_pair_type pair_high;

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Only pairs one:zero and three:two are ever named as sources
  assign pair_low = {i_dreg[1], i_dreg[0]};
  assign pair_high = {i_dreg[3], i_dreg[2]};

  // Pair and accumulator lines show a toggled pattern while valid is low; index lines pass through
  always_comb begin
    o_req = i_cmd;
    o_pair_0 = i_pair_swap ? pair_high : pair_low;
    o_pair_1 = i_pair_swap ? pair_low : pair_high;
    o_acc_zero = i_acc[0];
    o_acc_one = i_acc[1];
    o_idx_zero = i_idx[0];
    o_idx_one = i_idx[1];
    if (!i_cmd.valid) begin
      o_pair_0 = ~o_pair_0;
      o_pair_1 = ~o_pair_1;
      o_acc_zero = ~o_acc_zero;
      o_acc_one = ~o_acc_one;
    end
  end
endmodule

`default_nettype wire

/* tb/pbae_core_bench.sv */
// Self-checking bench for the packed byte add and extract slice
`timescale 1ns/1ps
`default_nettype none

module pbae_core_bench;
  localparam int TIME_LIMIT = 2000;
  localparam logic [39:0] EXT_T [4] = '{40'h00_7fff_7fff,
    40'hff_8000_8000, 40'h12_ffff_0001, 40'h00_8000_7fff};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  pbae_pkg::pbae_req_type cmd = '0;
  logic swap = 1'b0;
  logic [7:0][31:0] dreg = '0;
  logic [1:0][39:0] acc = '0;
  logic [1:0][31:0] idx = '0;
  logic [7:0][31:0] s_dreg = '0;
  logic [1:0][39:0] s_acc = '0;
  logic [1:0][1:0] s_off = '0;
  pbae_pkg::pbae_req_type req;
  pbae_pkg::pbae_pair_type pair0;
  pbae_pkg::pbae_pair_type pair1;
  logic [39:0] acc0;
  logic [39:0] acc1;
  logic [31:0] ix0;
  logic [31:0] ix1;
  pbae_pkg::pbae_result_type res;
  pbae_pkg::pbae_result_type last = '0;
  logic suppress;
  logic len32;
  logic flags;
  pbae_pkg::pbae_result_type expq[$];
  logic supq[$];
  int dueq[$];
  int bad_count = 0;
  int comparisons = 0;
  int seed = 9;
  int cycles = 0;

  // ****************************************************************
  // Clock, partner and design
  // ****************************************************************
  always #12.5 clk = ~clk;

  pbae_issue_model model_u (.i_cmd(cmd), .i_pair_swap(swap),
    .i_dreg(dreg), .i_acc(acc), .i_idx(idx), .o_req(req),
    .o_pair_0(pair0), .o_pair_1(pair1), .o_acc_zero(acc0),
    .o_acc_one(acc1), .o_idx_zero(ix0), .o_idx_one(ix1));

  pbae_core dut_u (.i_clk(clk), .i_rstn(rstn), .i_req(req),
    .i_accumulator_zero(acc0), .i_accumulator_one(acc1),
    .i_src_pair_0(pair0), .i_src_pair_1(pair1),
    .i_index_reg_zero(ix0), .i_index_reg_one(ix1), .o_result(res),
    .o_suppress_misalign(suppress), .o_insn_len32(len32),
    .o_flags_write(flags));

  // ****************************************************************
  // Reference arithmetic and compares
  // ****************************************************************
  function automatic logic [31:0] half_sum(input logic [39:0] a);
    return {{16{a[31]}}, a[31:16]} + {{16{a[15]}}, a[15:0]};
  endfunction

  function automatic logic [31:0] align(input logic [63:0] p,
      input logic r, input logic [1:0] o);
    logic [63:0] w;
    w = r ? {p[31:0], p[63:32]} : p;
    return w[o*8 +: 32];
  endfunction

  task automatic check_res(input string what,
      input pbae_pkg::pbae_result_type e,
      input pbae_pkg::pbae_result_type g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_bit(input string what, input logic e,
      input logic g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  // ****************************************************************
  // Driver: applies staged operands and notes the expected result
  // ****************************************************************
  task automatic scramble;
    for (int k = 0; k < 8; k++) begin
      s_dreg[k] = $random(seed);
    end
    s_acc[0] = {8'($random(seed)), 32'($random(seed))};
    s_acc[1] = {8'($random(seed)), 32'($random(seed))};
    s_off = 4'($random(seed));
  endtask

  task automatic issue(input logic v, input logic [1:0] op,
      input logic rev, input logic par);
    pbae_pkg::pbae_result_type e;
    logic [31:0] a0;
    logic [31:0] a1;
    logic [3:0][15:0] lanes;
    @(posedge clk);
    #1;
    dreg = s_dreg;
    acc = s_acc;
    idx = {$random(seed), $random(seed)};
    idx[0][1:0] = s_off[0];
    idx[1][1:0] = s_off[1];
    swap = 1'($random(seed));
    cmd = {v, op, rev, par, 3'($random(seed)), 3'($random(seed))};
    if (v && (op == 2'b01 || op == 2'b10)) begin
      e.valid = 1'b1;
      e.first_dest = cmd.first_dest;
      e.second_dest = cmd.second_dest;
      if (op == 2'b01) begin
        e.first_data = half_sum(acc[1]);
        e.second_data = half_sum(acc[0]);
      end else begin
        a0 = align(swap ? {dreg[3], dreg[2]} : {dreg[1], dreg[0]},
          rev, idx[0][1:0]);
        a1 = align(swap ? {dreg[1], dreg[0]} : {dreg[3], dreg[2]},
          rev, idx[1][1:0]);
        for (int k = 0; k < 4; k++) begin
          lanes[k] = 16'(a0[8*k +: 8]) + 16'(a1[8*k +: 8]);
        end
        e.first_data = {lanes[1], lanes[0]};
        e.second_data = {lanes[3], lanes[2]};
      end
      expq.push_back(e);
      supq.push_back(op == 2'b10);
      dueq.push_back(cycles + 1);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) issue(1'b0, 2'b00, 1'b0, 1'b0);
  endtask

  // ****************************************************************
  // Monitor: result due one cycle after each taken request
  // ****************************************************************
  always @(negedge clk) begin
    pbae_pkg::pbae_result_type e;
    logic due;
    logic sup;
    due = dueq.size() > 0 && dueq[0] == cycles;
    sup = 1'b0;
    if (!rstn) begin
      last = '0;
    end
    if (due) begin
      last = expq.pop_front();
      sup = supq.pop_front();
      void'(dueq.pop_front());
    end
    e = last;
    e.valid = due;
    check_res("result", e, res);
    check_bit("suppress", sup, suppress);
    check_bit("len32", due, len32);
    check_bit("flags", 1'b0, flags);
  end

  // Cycle count and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles >= TIME_LIMIT) begin
      bad_count++;
      $display("ERROR cycles expected below %0d seen %0d", TIME_LIMIT,
        cycles);
      conclude();
    end
  end

  task automatic conclude;
    if (dueq.size() != 0) begin
      bad_count++;
      $display("ERROR pending expected 0 seen %0d", dueq.size());
    end
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    // Extraction, sign boundaries first, back to back
    for (int t = 0; t < 8; t++) begin
      scramble();
      if (t < 4) s_acc = {EXT_T[t], EXT_T[3-t]};
      issue(1'b1, 2'b01, t[0], t[1]);
    end
    $display("test extract done");
    // Quad add over every offset pair, both orders, all-ones last
    for (int o = 0; o < 32; o++) begin
      scramble();
      s_off = o[3:0];
      if (o == 31) s_dreg = '1;
      issue(1'b1, 2'b10, o[4], o[0]);
    end
    $display("test quad_add done");
    // Ignored requests leave results held
    issue(1'b1, 2'b00, 1'b0, 1'b0);
    issue(1'b1, 2'b11, 1'b0, 1'b0);
    issue(1'b0, 2'b10, 1'b1, 1'b0);
    idle(2);
    $display("test refused done");
    // Random mix with the multi-issue bit set at random
    repeat (40) begin
      scramble();
      issue(1'($random(seed)), 2'($random(seed)), 1'($random(seed)),
        1'($random(seed)));
    end
    idle(2);
    $display("test mixed done");
    // Reset in mid-run clears outputs, then work resumes
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    scramble();
    issue(1'b1, 2'b10, 1'b1, 1'b1);
    idle(3);
    $display("test reset done");
    conclude();
  end
endmodule

`default_nettype wire
